/* File: shared/mcs_pkg.sv */
// constants for the core special function register set
`default_nettype none
package mcs_pkg;
	localparam int         DATA_W            = 8;
	localparam int         PTR_W             = 16;
	localparam int         STRETCH_W         = 3;
	localparam int         BANK_W            = 5;
	// direct addresses of the registers with behaviour of their own
	localparam logic [7:0] ADDR_STACK_TOP    = 8'h81;
	localparam logic [7:0] ADDR_PTR0_LOW     = 8'h82;
	localparam logic [7:0] ADDR_PTR0_HIGH    = 8'h83;
	localparam logic [7:0] ADDR_PTR1_LOW     = 8'h84;
	localparam logic [7:0] ADDR_PTR1_HIGH    = 8'h85;
	localparam logic [7:0] ADDR_PTR_SELECT   = 8'h92;
	localparam logic [7:0] ADDR_PROG_STATUS  = 8'hD0;
	localparam logic [7:0] ADDR_BAUD_CTRL    = 8'hD8;
	localparam logic [7:0] ADDR_ACCUMULATOR  = 8'hE0;
	localparam logic [7:0] ADDR_MUL_OPERAND  = 8'hF0;
	// direct addresses of plain storage registers
	localparam logic [7:0] ADDR_PORT0        = 8'h80;
	localparam logic [7:0] ADDR_POWER_CTRL   = 8'h87;
	localparam logic [7:0] ADDR_TIMER_CTRL   = 8'h88;
	localparam logic [7:0] ADDR_TIMER_MODE   = 8'h89;
	localparam logic [7:0] ADDR_TIMER0_LOW   = 8'h8A;
	localparam logic [7:0] ADDR_TIMER1_LOW   = 8'h8B;
	localparam logic [7:0] ADDR_TIMER0_HIGH  = 8'h8C;
	localparam logic [7:0] ADDR_TIMER1_HIGH  = 8'h8D;
	localparam logic [7:0] ADDR_STRETCH      = 8'h8E;
	localparam logic [7:0] ADDR_PORT1        = 8'h90;
	localparam logic [7:0] ADDR_SER0_CTRL    = 8'h98;
	localparam logic [7:0] ADDR_SER0_BUF     = 8'h99;
	localparam logic [7:0] ADDR_IRQ_EN2      = 8'h9A;
	localparam logic [7:0] ADDR_SER1_CTRL    = 8'h9B;
	localparam logic [7:0] ADDR_SER1_BUF     = 8'h9C;
	localparam logic [7:0] ADDR_SER1_RLD_LO  = 8'h9D;
	localparam logic [7:0] ADDR_PORT2        = 8'hA0;
	localparam logic [7:0] ADDR_IRQ_EN0      = 8'hA8;
	localparam logic [7:0] ADDR_IRQ_PRI0     = 8'hA9;
	localparam logic [7:0] ADDR_SER0_RLD_LO  = 8'hAA;
	localparam logic [7:0] ADDR_PORT3        = 8'hB0;
	localparam logic [7:0] ADDR_IRQ_EN1      = 8'hB8;
	localparam logic [7:0] ADDR_IRQ_PRI1     = 8'hB9;
	localparam logic [7:0] ADDR_SER0_RLD_HI  = 8'hBA;
	localparam logic [7:0] ADDR_SER1_RLD_HI  = 8'hBB;
	localparam logic [7:0] ADDR_PAGED_HIGH   = 8'hBF;
	localparam logic [7:0] ADDR_IRQ_REQUEST  = 8'hC0;
	localparam logic [7:0] ADDR_IRQ_POLARITY = 8'hC8;
	// reset values
	localparam logic [7:0] RST_ZERO          = 8'h00;
	localparam logic [7:0] RST_PORT          = 8'hFF;
	localparam logic [7:0] RST_STACK_TOP     = 8'h07;
	localparam logic [7:0] RST_STRETCH       = 8'h01;
	localparam logic [7:0] RST_SER0_RLD_LO   = 8'hD9;
	localparam logic [7:0] RST_RELOAD_HIGH   = 8'h03;
	// status word and other field positions
	localparam int         BIT_CARRY         = 7;
	localparam int         BIT_AUX_CARRY     = 6;
	localparam int         BIT_GENERAL       = 5;
	localparam int         BIT_BANK_HI       = 4;
	localparam int         BIT_BANK_LO       = 3;
	localparam int         BIT_OVERFLOW      = 2;
	localparam int         BIT_USER          = 1;
	localparam int         BIT_PARITY        = 0;
	localparam int         BIT_PTR_SELECT    = 0;
	localparam int         BIT_BAUD_DOUBLE   = 7;
	// plain storage table, entry index order
	localparam int         NUM_GEN           = 28;
	localparam int         IDX_PORT0         = 0;
	localparam int         IDX_POWER         = 1;
	localparam int         IDX_STRETCH       = 8;
	localparam int         IDX_PORT1         = 9;
	localparam int         IDX_PORT2         = 16;
	localparam int         IDX_SER0_RLD_LO   = 19;
	localparam int         IDX_PORT3         = 20;
	localparam int         IDX_SER0_RLD_HI   = 23;
	localparam int         IDX_SER1_RLD_HI   = 24;
	localparam int         IDX_PAGED         = 25;
	localparam int         IDX_POLARITY      = 27;
	localparam logic [7:0] GEN_ADDR [NUM_GEN] = '{
		ADDR_PORT0, ADDR_POWER_CTRL, ADDR_TIMER_CTRL, ADDR_TIMER_MODE,
		ADDR_TIMER0_LOW, ADDR_TIMER1_LOW, ADDR_TIMER0_HIGH, ADDR_TIMER1_HIGH,
		ADDR_STRETCH, ADDR_PORT1, ADDR_SER0_CTRL, ADDR_SER0_BUF,
		ADDR_IRQ_EN2, ADDR_SER1_CTRL, ADDR_SER1_BUF, ADDR_SER1_RLD_LO,
		ADDR_PORT2, ADDR_IRQ_EN0, ADDR_IRQ_PRI0, ADDR_SER0_RLD_LO,
		ADDR_PORT3, ADDR_IRQ_EN1, ADDR_IRQ_PRI1, ADDR_SER0_RLD_HI,
		ADDR_SER1_RLD_HI, ADDR_PAGED_HIGH, ADDR_IRQ_REQUEST, ADDR_IRQ_POLARITY};
	localparam logic [7:0] GEN_RST [NUM_GEN] = '{
		RST_PORT, RST_ZERO, RST_ZERO, RST_ZERO,
		RST_ZERO, RST_ZERO, RST_ZERO, RST_ZERO,
		RST_STRETCH, RST_PORT, RST_ZERO, RST_ZERO,
		RST_ZERO, RST_ZERO, RST_ZERO, RST_ZERO,
		RST_PORT, RST_ZERO, RST_ZERO, RST_SER0_RLD_LO,
		RST_PORT, RST_ZERO, RST_ZERO, RST_RELOAD_HIGH,
		RST_RELOAD_HIGH, RST_ZERO, RST_ZERO, RST_ZERO};
endpackage : mcs_pkg
`default_nettype wire

/* File: logic/mcs_core_sfr.sv */
// core special function registers: accumulator, status word, pointers, stack
`timescale 1ns/1ns
`default_nettype none

// What this block does
// [RQ1] On reset every register loads its listed value: ports FF, stack 07, stretch 01.
// [RQ2] Accumulator at E0 holds the default operand, written by software or the ALU.
// [RQ3] Operand register at F0 takes multiply/divide results, else plain scratch byte.
// [RQ4] Two status bits pick the working bank: 00 at 00-07 up to 11 at 18-1F.
// [RQ5] Status bit 0 is hardware parity so accumulator plus bit is even.
// [RQ6] Status bit 5 is a general flag software sets and clears freely.
// [RQ7] First serial reload low byte at AA resets to D9.
// [RQ8] Both serial reload high bytes reset to 03.
// [RQ9] Paged register at BF gives the upper byte for indirect external moves.
// [RQ10] Baud control keeps only its top bit; the others read zero.
// [RQ11] Register at C8 holds interrupt two and three polarity, reset zero.
// [RQ12] Power register holds serial speed, idle and stop controls, reset zero.
// [RQ13] Pointer select register exists at 92 and resets to zero.
// [RQ14] Select bit 0 picks first or second pointer; both values stay intact.
// [RQ15] Stack pointer increments before each push that has no pop or stack write in the same cycle, so the stack starts at 08.
// [RQ16] Status bits 7,6,2,1 are carry, aux carry, overflow and user flag.
module mcs_core_sfr (
	input  wire logic        clock,             // 20 MHz core clock
	input  wire logic        resetn,            // asynchronous reset, active low
	input  wire logic [7:0]  sfrAddr,           // direct address
	input  wire logic        sfrWrEn,           // write strobe
	input  wire logic [7:0]  sfrWrData,         // write data
	input  wire logic        sfrRdEn,           // read strobe
	output logic      [7:0]  sfrRdData,         // read data, one cycle later
	input  wire logic        aluAccWe,          // ALU result to accumulator
	input  wire logic [7:0]  aluAccData,        // ALU result byte
	input  wire logic        aluOperandWe,      // multiply/divide second result
	input  wire logic [7:0]  aluOperandData,    // second result byte
	input  wire logic        aluFlagWe,         // ALU flag update
	input  wire logic        aluCarry,          // new carry
	input  wire logic        aluAuxCarry,       // new aux carry
	input  wire logic        aluOverflow,       // new overflow
	input  wire logic        stackPush,         // push or call
	input  wire logic        stackPop,          // pop or return
	input  wire logic        aluPtrWe,          // write to the active pointer
	input  wire logic [15:0] aluPtrData,        // new active pointer value
	output logic      [7:0]  accumulatorOut,    // accumulator
	output logic      [7:0]  operandOut,        // multiply operand
	output logic      [7:0]  programStatusOut,  // status word
	output logic      [4:0]  bankBaseOut,       // base address of working bank
	output logic      [15:0] activePointerOut,  // selected data pointer
	output logic      [7:0]  stackTopOut,       // stack pointer
	output logic      [7:0]  pagedAddrOut,      // upper byte for paged moves
	output logic      [7:0]  portZeroOut,       // port 0 latch
	output logic      [7:0]  portOneOut,        // port 1 latch
	output logic      [7:0]  portTwoOut,        // port 2 latch
	output logic      [7:0]  portThreeOut,      // port 3 latch
	output logic      [2:0]  stretchOut,        // memory stretch value
	output logic      [7:0]  powerCtrlOut,      // speed, idle and stop controls
	output logic      [7:0]  irqPolarityOut,    // interrupt two/three polarity
	output logic             baudDoubleOut,     // baud control top bit
	output logic      [15:0] serial0ReloadOut,  // serial 0 reload value
	output logic      [7:0]  serial1ReloadHiOut // serial 1 reload high byte
);
	logic [7:0]  genReg_reg [mcs_pkg::NUM_GEN];
	logic [7:0]  acc_reg;
	logic [7:0]  accNext;
	logic [7:0]  operand_reg;
	logic [7:0]  status_reg;
	logic [7:0]  statusNext;
	logic [7:0]  stackTop_reg;
	logic [15:0] ptr0_reg;
	logic [15:0] ptr0Next;
	logic [15:0] ptr1_reg;
	logic [15:0] ptr1Next;
	logic [7:0]  ptrSel_reg;
	logic [7:0]  ptrSelNext;
	logic        baudDouble_reg;
	logic [15:0] activePtr_reg;
	logic [4:0]  bankBase_reg;
	logic [7:0]  rdData_reg;
	logic [7:0]  rdMux;
	logic        wrAcc;
	logic        wrOperand;
	logic        wrStatus;
	logic        wrStack;
	logic        wrSel;

	assign wrAcc     = sfrWrEn && (sfrAddr == mcs_pkg::ADDR_ACCUMULATOR);
	assign wrOperand = sfrWrEn && (sfrAddr == mcs_pkg::ADDR_MUL_OPERAND);
	assign wrStatus  = sfrWrEn && (sfrAddr == mcs_pkg::ADDR_PROG_STATUS);
	assign wrStack   = sfrWrEn && (sfrAddr == mcs_pkg::ADDR_STACK_TOP);
	assign wrSel     = sfrWrEn && (sfrAddr == mcs_pkg::ADDR_PTR_SELECT);

	// plain storage registers, one per table entry
	genvar gi;
	generate
		for (gi = 0; gi < mcs_pkg::NUM_GEN; gi++) begin : genStore
			always_ff @(posedge clock or negedge resetn) begin
				if (!resetn) begin
					genReg_reg[gi] <= mcs_pkg::GEN_RST[gi]; // RQ1 RQ7 RQ8 RQ9 RQ11 RQ12
				end else if (sfrWrEn && (sfrAddr == mcs_pkg::GEN_ADDR[gi])) begin
					genReg_reg[gi] <= sfrWrData;
				end
			end
		end
	endgenerate

	// a direct write wins over an ALU write in the same cycle
	always_comb begin
		accNext = acc_reg;
		if (wrAcc) begin
			accNext = sfrWrData; // RQ2
		end else if (aluAccWe) begin
			accNext = aluAccData; // RQ2
		end
	end

	always_ff @(posedge clock or negedge resetn) begin
		if (!resetn) begin
			acc_reg <= mcs_pkg::RST_ZERO;
		end else begin
			acc_reg <= accNext;
		end
	end

	always_ff @(posedge clock or negedge resetn) begin
		if (!resetn) begin
			operand_reg <= mcs_pkg::RST_ZERO;
		end else if (wrOperand) begin
			operand_reg <= sfrWrData; // RQ3
		end else if (aluOperandWe) begin
			operand_reg <= aluOperandData; // RQ3
		end
	end

	// parity follows the next accumulator value, so it never lags a cycle
	always_comb begin
		statusNext = status_reg;
		if (aluFlagWe) begin
			statusNext[mcs_pkg::BIT_CARRY]     = aluCarry; // RQ16
			statusNext[mcs_pkg::BIT_AUX_CARRY] = aluAuxCarry; // RQ16
			statusNext[mcs_pkg::BIT_OVERFLOW]  = aluOverflow; // RQ16
		end
		if (wrStatus) begin
			statusNext = sfrWrData; // RQ4 RQ6 RQ16
		end
		statusNext[mcs_pkg::BIT_PARITY] = ^accNext; // RQ5
	end

	always_ff @(posedge clock or negedge resetn) begin
		if (!resetn) begin
			status_reg <= mcs_pkg::RST_ZERO;
		end else begin
			status_reg <= statusNext;
		end
	end

	always_ff @(posedge clock or negedge resetn) begin
		if (!resetn) begin
			bankBase_reg <= 5'h00;
		end else begin
			bankBase_reg <= {statusNext[mcs_pkg::BIT_BANK_HI],
				statusNext[mcs_pkg::BIT_BANK_LO], 3'h0}; // RQ4
		end
	end

	// pre-increment: the first push after reset lands at 08
	always_ff @(posedge clock or negedge resetn) begin
		if (!resetn) begin
			stackTop_reg <= mcs_pkg::RST_STACK_TOP; // RQ1
		end else if (wrStack) begin
			stackTop_reg <= sfrWrData;
		end else if (stackPush && !stackPop) begin
			stackTop_reg <= stackTop_reg + 8'h01; // RQ15
		end else if (stackPop && !stackPush) begin
			stackTop_reg <= stackTop_reg - 8'h01;
		end
	end

	// pointer writes touch only the selected pointer; byte writes come last
	always_comb begin
		ptrSelNext = wrSel ? sfrWrData : ptrSel_reg; // RQ13
		ptr0Next   = ptr0_reg;
		ptr1Next   = ptr1_reg;
		if (aluPtrWe) begin
			if (ptrSel_reg[mcs_pkg::BIT_PTR_SELECT]) begin
				ptr1Next = aluPtrData; // RQ14
			end else begin
				ptr0Next = aluPtrData; // RQ14
			end
		end
		if (sfrWrEn) begin
			case (sfrAddr)
				mcs_pkg::ADDR_PTR0_LOW: begin
					ptr0Next[7:0] = sfrWrData;
				end
				mcs_pkg::ADDR_PTR0_HIGH: begin
					ptr0Next[15:8] = sfrWrData;
				end
				mcs_pkg::ADDR_PTR1_LOW: begin
					ptr1Next[7:0] = sfrWrData;
				end
				mcs_pkg::ADDR_PTR1_HIGH: begin
					ptr1Next[15:8] = sfrWrData;
				end
				default: begin
				end
			endcase
		end
	end

	always_ff @(posedge clock or negedge resetn) begin
		if (!resetn) begin
			ptr0_reg   <= {mcs_pkg::RST_ZERO, mcs_pkg::RST_ZERO};
			ptr1_reg   <= {mcs_pkg::RST_ZERO, mcs_pkg::RST_ZERO};
			ptrSel_reg <= mcs_pkg::RST_ZERO; // RQ13
		end else begin
			ptr0_reg   <= ptr0Next;
			ptr1_reg   <= ptr1Next;
			ptrSel_reg <= ptrSelNext;
		end
	end

	// mirrored so the output is a flop yet tracks a select toggle at once
	always_ff @(posedge clock or negedge resetn) begin
		if (!resetn) begin
			activePtr_reg <= {mcs_pkg::RST_ZERO, mcs_pkg::RST_ZERO};
		end else begin
			activePtr_reg <= ptrSelNext[mcs_pkg::BIT_PTR_SELECT] ? ptr1Next : ptr0Next; // RQ14
		end
	end

	always_ff @(posedge clock or negedge resetn) begin
		if (!resetn) begin
			baudDouble_reg <= 1'b0;
		end else if (sfrWrEn && (sfrAddr == mcs_pkg::ADDR_BAUD_CTRL)) begin
			baudDouble_reg <= sfrWrData[mcs_pkg::BIT_BAUD_DOUBLE]; // RQ10
		end
	end

	// unmapped addresses read as zero
	always_comb begin
		rdMux = 8'h00;
		case (sfrAddr)
			mcs_pkg::ADDR_ACCUMULATOR: begin
				rdMux = acc_reg;
			end
			mcs_pkg::ADDR_MUL_OPERAND: begin
				rdMux = operand_reg;
			end
			mcs_pkg::ADDR_PROG_STATUS: begin
				rdMux = status_reg;
			end
			mcs_pkg::ADDR_STACK_TOP: begin
				rdMux = stackTop_reg;
			end
			mcs_pkg::ADDR_PTR0_LOW: begin
				rdMux = ptr0_reg[7:0];
			end
			mcs_pkg::ADDR_PTR0_HIGH: begin
				rdMux = ptr0_reg[15:8];
			end
			mcs_pkg::ADDR_PTR1_LOW: begin
				rdMux = ptr1_reg[7:0];
			end
			mcs_pkg::ADDR_PTR1_HIGH: begin
				rdMux = ptr1_reg[15:8];
			end
			mcs_pkg::ADDR_PTR_SELECT: begin
				rdMux = ptrSel_reg;
			end
			mcs_pkg::ADDR_BAUD_CTRL: begin
				rdMux = {baudDouble_reg, 7'h00}; // RQ10
			end
			default: begin
				for (int i = 0; i < mcs_pkg::NUM_GEN; i++) begin
					if (sfrAddr == mcs_pkg::GEN_ADDR[i]) begin
						rdMux = genReg_reg[i];
					end
				end
			end
		endcase
	end

	// read returns the value before any write in the same cycle
	always_ff @(posedge clock or negedge resetn) begin
		if (!resetn) begin
			rdData_reg <= 8'h00;
		end else if (sfrRdEn) begin
			rdData_reg <= rdMux;
		end
	end

	assign sfrRdData          = rdData_reg;
	assign accumulatorOut     = acc_reg;
	assign operandOut         = operand_reg;
	assign programStatusOut   = status_reg;
	assign bankBaseOut        = bankBase_reg;
	assign activePointerOut   = activePtr_reg;
	assign stackTopOut        = stackTop_reg;
	assign pagedAddrOut       = genReg_reg[mcs_pkg::IDX_PAGED]; // RQ9
	assign portZeroOut        = genReg_reg[mcs_pkg::IDX_PORT0];
	assign portOneOut         = genReg_reg[mcs_pkg::IDX_PORT1];
	assign portTwoOut         = genReg_reg[mcs_pkg::IDX_PORT2];
	assign portThreeOut       = genReg_reg[mcs_pkg::IDX_PORT3];
	assign stretchOut         = genReg_reg[mcs_pkg::IDX_STRETCH][mcs_pkg::STRETCH_W-1:0];
	assign powerCtrlOut       = genReg_reg[mcs_pkg::IDX_POWER]; // RQ12
	assign irqPolarityOut     = genReg_reg[mcs_pkg::IDX_POLARITY]; // RQ11
	assign baudDoubleOut      = baudDouble_reg;
	assign serial0ReloadOut   = {genReg_reg[mcs_pkg::IDX_SER0_RLD_HI],
		genReg_reg[mcs_pkg::IDX_SER0_RLD_LO]};
	assign serial1ReloadHiOut = genReg_reg[mcs_pkg::IDX_SER1_RLD_HI];
endmodule : mcs_core_sfr
`default_nettype wire

/* File: verif/mcs_core_sfr_properties.sv */
// assertions on the ports of the core register set
`timescale 1ns/1ns
`default_nettype none
module mcs_core_sfr_properties (
	input wire logic        clock,            // core clock
	input wire logic        resetn,           // async reset, active low
	input wire logic [7:0]  sfrAddr,          // direct address
	input wire logic        sfrWrEn,          // write strobe
	input wire logic [7:0]  sfrWrData,        // write data
	input wire logic        sfrRdEn,          // read strobe
	input wire logic [7:0]  sfrRdData,        // read data
	input wire logic        aluOperandWe,     // second result strobe
	input wire logic [7:0]  aluOperandData,   // second result
	input wire logic        aluFlagWe,        // flag update
	input wire logic        aluCarry,         // new carry
	input wire logic        aluOverflow,      // new overflow
	input wire logic        stackPush,        // push
	input wire logic        stackPop,         // pop
	input wire logic        aluPtrWe,         // pointer write
	input wire logic [15:0] aluPtrData,       // pointer value
	input wire logic [7:0]  accumulatorOut,   // accumulator
	input wire logic [7:0]  operandOut,       // operand
	input wire logic [7:0]  programStatusOut, // status word
	input wire logic [4:0]  bankBaseOut,      // bank base
	input wire logic [15:0] activePointerOut, // active pointer
	input wire logic [7:0]  stackTopOut,      // stack pointer
	input wire logic        baudDoubleOut     // baud top bit
);
	default clocking cb @(posedge clock); endclocking
	default disable iff (!resetn);
	property p_parity; programStatusOut[0] == ^accumulatorOut; endproperty
	a_parity: assert property (p_parity) else $error("parity bit wrong");
	property p_bank; bankBaseOut == {programStatusOut[4:3], 3'b000}; endproperty
	a_bank: assert property (p_bank) else $error("bank base wrong");
	property p_push;
		stackPush && !stackPop && !(sfrWrEn && sfrAddr == 8'h81)
			|=> stackTopOut == $past(stackTopOut) + 8'h01;
	endproperty
	a_push: assert property (p_push) else $error("push did not increment");
	property p_acc; sfrWrEn && sfrAddr == 8'hE0 |=> accumulatorOut == $past(sfrWrData); endproperty
	a_acc: assert property (p_acc) else $error("accumulator write lost");
	property p_operand; aluOperandWe && !sfrWrEn |=> operandOut == $past(aluOperandData); endproperty
	a_operand: assert property (p_operand) else $error("operand result lost");
	property p_general;
		sfrWrEn && sfrAddr == 8'hD0 |=> programStatusOut[5] == $past(sfrWrData[5]);
	endproperty
	a_general: assert property (p_general) else $error("general flag wrong");
	property p_flags;
		aluFlagWe && !sfrWrEn |=> programStatusOut[7] == $past(aluCarry)
			&& programStatusOut[2] == $past(aluOverflow);
	endproperty
	a_flags: assert property (p_flags) else $error("alu flags wrong");
	property p_baud; sfrWrEn && sfrAddr == 8'hD8 |=> baudDoubleOut == $past(sfrWrData[7]); endproperty
	a_baud: assert property (p_baud) else $error("baud bit wrong");
	property p_ptr; aluPtrWe && !sfrWrEn |=> activePointerOut == $past(aluPtrData); endproperty
	a_ptr: assert property (p_ptr) else $error("active pointer not written");
	// read data must hold between strobes, a bus master may sample late
	property p_rd_hold; !sfrRdEn |=> $stable(sfrRdData); endproperty
	a_rd_hold: assert property (p_rd_hold) else $error("read data moved");
	// first edge after release still shows the values loaded by reset
	property p_reset;
		$rose(resetn) |-> stackTopOut == 8'h07 && accumulatorOut == 8'h00
			&& activePointerOut == 16'h0000 && bankBaseOut == 5'h00;
	endproperty
	a_reset: assert property (p_reset) else $error("reset value wrong");
	c_push: cover property (stackPush);
	c_ptr: cover property (aluPtrWe);
	c_status: cover property (sfrWrEn && sfrAddr == 8'hD0);
endmodule : mcs_core_sfr_properties
bind mcs_core_sfr mcs_core_sfr_properties chk_u (.clock(clock), .resetn(resetn),
	.sfrAddr(sfrAddr), .sfrWrEn(sfrWrEn), .sfrWrData(sfrWrData), .sfrRdEn(sfrRdEn),
	.sfrRdData(sfrRdData), .aluOperandWe(aluOperandWe), .aluOperandData(aluOperandData),
	.aluFlagWe(aluFlagWe), .aluCarry(aluCarry), .aluOverflow(aluOverflow),
	.stackPush(stackPush), .stackPop(stackPop), .aluPtrWe(aluPtrWe), .aluPtrData(aluPtrData),
	.accumulatorOut(accumulatorOut), .operandOut(operandOut),
	.programStatusOut(programStatusOut), .bankBaseOut(bankBaseOut),
	.activePointerOut(activePointerOut), .stackTopOut(stackTopOut),
	.baudDoubleOut(baudDoubleOut));
`default_nettype wire

/* File: verif/tb_top.sv */
// self-checking bench for the core register set
`timescale 1ns/1ns
`default_nettype none
module tb_top;
	logic        clock, resetn, sfrWrEn, sfrRdEn, aluAccWe, aluOperandWe, aluFlagWe;
	logic        aluCarry, aluAuxCarry, aluOverflow, stackPush, stackPop, aluPtrWe;
	logic        baudDoubleOut;
	logic [7:0]  sfrAddr, sfrWrData, sfrRdData, aluAccData, aluOperandData;
	logic [7:0]  accumulatorOut, operandOut, programStatusOut, stackTopOut, pagedAddrOut;
	logic [7:0]  portZeroOut, portOneOut, portTwoOut, portThreeOut, powerCtrlOut;
	logic [7:0]  irqPolarityOut, serial1ReloadHiOut;
	logic [4:0]  bankBaseOut;
	logic [2:0]  stretchOut;
	logic [15:0] aluPtrData, activePointerOut, serial0ReloadOut;
	int          n_mismatch = 0;
	int          checks_done = 0;
	logic [7:0]  v;

	mcs_core_sfr dut_u (.clock(clock), .resetn(resetn), .sfrAddr(sfrAddr), .sfrWrEn(sfrWrEn),
		.sfrWrData(sfrWrData), .sfrRdEn(sfrRdEn), .sfrRdData(sfrRdData), .aluAccWe(aluAccWe),
		.aluAccData(aluAccData), .aluOperandWe(aluOperandWe), .aluOperandData(aluOperandData),
		.aluFlagWe(aluFlagWe), .aluCarry(aluCarry), .aluAuxCarry(aluAuxCarry),
		.aluOverflow(aluOverflow), .stackPush(stackPush), .stackPop(stackPop),
		.aluPtrWe(aluPtrWe), .aluPtrData(aluPtrData), .accumulatorOut(accumulatorOut),
		.operandOut(operandOut), .programStatusOut(programStatusOut), .bankBaseOut(bankBaseOut),
		.activePointerOut(activePointerOut), .stackTopOut(stackTopOut),
		.pagedAddrOut(pagedAddrOut), .portZeroOut(portZeroOut), .portOneOut(portOneOut),
		.portTwoOut(portTwoOut), .portThreeOut(portThreeOut), .stretchOut(stretchOut),
		.powerCtrlOut(powerCtrlOut), .irqPolarityOut(irqPolarityOut),
		.baudDoubleOut(baudDoubleOut), .serial0ReloadOut(serial0ReloadOut),
		.serial1ReloadHiOut(serial1ReloadHiOut));

	initial begin
		clock = 1'b0;
		forever #25 clock = ~clock;
	end

	task automatic cmp(input logic [15:0] got, input logic [15:0] exp);
		checks_done++;
		if (got !== exp) begin
			n_mismatch++;
			$display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : cmp

	// strobes last exactly one cycle; everything is launched at a falling edge
	task automatic tick();
		@(negedge clock);
		{sfrWrEn, sfrRdEn, aluAccWe, aluOperandWe, aluFlagWe} = 5'h00;
		{stackPush, stackPop, aluPtrWe} = 3'h0;
	endtask : tick

	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		sfrAddr = a;
		sfrWrData = d;
		sfrWrEn = 1'b1;
		tick();
		@(negedge clock);
	endtask : wr

	task automatic rd(input logic [7:0] a, input logic [7:0] exp);
		sfrAddr = a;
		sfrRdEn = 1'b1;
		tick();
		cmp(16'(sfrRdData), 16'(exp));
		@(negedge clock);
	endtask : rd

	task automatic give_verdict();
		$display("mismatches %0d, checks %0d", n_mismatch, checks_done);
		if (n_mismatch == 0 && checks_done > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask : give_verdict

	initial begin
		repeat (5000) @(posedge clock);
		n_mismatch++;
		give_verdict();
	end

	initial begin
		resetn = 1'b0;
		{sfrAddr, sfrWrData, aluAccData, aluOperandData, aluPtrData} = 48'h0;
		{aluCarry, aluAuxCarry, aluOverflow} = 3'h0;
		{sfrWrEn, sfrRdEn, aluAccWe, aluOperandWe, aluFlagWe} = 5'h00;
		{stackPush, stackPop, aluPtrWe} = 3'h0;
		repeat (12) @(negedge clock);
		resetn = 1'b1;
		@(negedge clock);
		cmp({portZeroOut, portOneOut}, 16'hFFFF);
		cmp({portTwoOut, portThreeOut}, 16'hFFFF);
		cmp({13'h0000, stretchOut}, 16'h0001);
		cmp(serial0ReloadOut, 16'h03D9);
		cmp({8'h00, serial1ReloadHiOut}, 16'h0003);
		cmp({pagedAddrOut, irqPolarityOut}, 16'h0000);
		cmp({powerCtrlOut, stackTopOut}, 16'h0007);
		cmp(activePointerOut, 16'h0000);
		for (int i = 0; i < mcs_pkg::NUM_GEN; i++)
			rd(mcs_pkg::GEN_ADDR[i], mcs_pkg::GEN_RST[i]);
		rd(8'h92, 8'h00);
		rd(8'h81, 8'h07);
		for (int i = 0; i < mcs_pkg::NUM_GEN; i++) begin
			wr(mcs_pkg::GEN_ADDR[i], 8'h5A ^ 8'(i));
			rd(mcs_pkg::GEN_ADDR[i], 8'h5A ^ 8'(i));
		end
		cmp(16'(pagedAddrOut), 16'(8'h5A ^ 8'(mcs_pkg::IDX_PAGED)));
		cmp(16'(irqPolarityOut), 16'(8'h5A ^ 8'(mcs_pkg::IDX_POLARITY)));
		for (int i = 0; i <= 8; i++) begin
			v = 8'((9'h001 << i) - 9'h001);
			wr(8'hE0, v);
			cmp(16'(accumulatorOut), 16'(v));
			rd(8'hD0, {7'h00, i[0]});
		end
		// software cannot force parity: accumulator is FF, eight ones
		wr(8'hD0, 8'h01);
		rd(8'hD0, 8'h00);
		for (int bank = 0; bank < 4; bank++) begin
			wr(8'hD0, 8'h20 | 8'(bank << 3));
			cmp(16'(bankBaseOut), 16'(bank * 8));
			rd(8'hD0, 8'h20 | 8'(bank << 3));
		end
		wr(8'hD0, 8'h00);
		rd(8'hD0, 8'h00);
		wr(8'hD8, 8'hFF);
		rd(8'hD8, 8'h80);
		cmp(16'(baudDoubleOut), 16'h0001);
		wr(8'hE1, 8'hFF);
		rd(8'hE1, 8'h00);
		wr(8'hF0, 8'hC3);
		rd(8'hF0, 8'hC3);
		aluOperandWe = 1'b1;
		aluOperandData = 8'h3C;
		tick();
		cmp(16'(operandOut), 16'h003C);
		@(negedge clock);
		{aluFlagWe, aluCarry, aluAuxCarry, aluOverflow} = 4'hF;
		tick();
		cmp(16'(programStatusOut), 16'h00C4);
		@(negedge clock);
		aluAccWe = 1'b1;
		aluAccData = 8'h07;
		tick();
		cmp(16'(programStatusOut), 16'h00C5);
		@(negedge clock);
		// direct write and ALU result in one cycle: the direct write wins
		aluAccWe = 1'b1;
		aluAccData = 8'h22;
		wr(8'hE0, 8'h11);
		cmp(16'(accumulatorOut), 16'h0011);
		stackPush = 1'b1;
		tick();
		cmp(16'(stackTopOut), 16'h0008);
		@(negedge clock);
		{stackPush, stackPop} = 2'b11;
		tick();
		cmp(16'(stackTopOut), 16'h0008);
		@(negedge clock);
		stackPop = 1'b1;
		tick();
		cmp(16'(stackTopOut), 16'h0007);
		@(negedge clock);
		wr(8'h82, 8'h11);
		wr(8'h83, 8'h22);
		wr(8'h84, 8'h33);
		wr(8'h85, 8'h44);
		cmp(activePointerOut, 16'h2211);
		wr(8'h92, 8'h01);
		cmp(activePointerOut, 16'h4433);
		rd(8'h92, 8'h01);
		aluPtrWe = 1'b1;
		aluPtrData = 16'hBEEF;
		tick();
		@(negedge clock);
		rd(8'h84, 8'hEF);
		rd(8'h85, 8'hBE);
		rd(8'h82, 8'h11);
		wr(8'h92, 8'h00);
		cmp(activePointerOut, 16'h2211);
		resetn = 1'b0;
		@(negedge clock);
		cmp({stackTopOut, 8'h00}, 16'h0700);
		cmp(serial0ReloadOut, 16'h03D9);
		resetn = 1'b1;
		@(negedge clock);
		give_verdict();
	end
endmodule : tb_top
`default_nettype wire
